// >>> bench/rlps_peer_model.sv
// Behavioural model of the other controllers of one rise group.
// Assumes the block under test is one member; the bench commands the peers.
`timescale 1ns/1ps
`default_nettype none
module rlps_peer_model (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Local member and bench commands
	input wire logic local_permit,
	input wire logic rise_abort_req,
	input wire logic peer_ok,
	input wire logic peer_abort,
	input wire logic slow,
	// Group lines
	output logic grp_permit_all,
	output logic grp_abort
);
	logic [3:0] all_r;
	logic [3:0] ab_r;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			all_r <= 4'h0;
			ab_r <= 4'h0;
		end
		else
		begin
			all_r <= {all_r[2:0], local_permit & peer_ok};
			ab_r <= {ab_r[2:0], rise_abort_req | peer_abort};
		end
	end
	// Slow peers answer three cycles later, as over a busy link
	assign grp_permit_all = slow ? all_r[3] : all_r[0];
	assign grp_abort = slow ? ab_r[3] : ab_r[0];
endmodule
`default_nettype wire

// >>> bench/rlps_top_test.sv
// Self-checking bench for the rise supervisor with a peer group model.
// Assumes the learning and supply-loss counts are shortened by parameter.
`timescale 1ns/1ps
`default_nettype none
module rlps_top_test;
	import rlps_pkg::*;
	localparam int TMO = 200;
	localparam int PF = 10;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	rlps_axi_req_t req = '0;
	rlps_axi_rsp_t rsp;
	rlps_pv_t pv = '0;
	logic pv_under = 1'b0;
	logic pv_over = 1'b0;
	logic brk = 1'b0;
	logic pwr = 1'b0;
	logic ifail = 1'b0;
	logic peer_ok = 1'b0;
	logic peer_abort = 1'b0;
	logic slow = 1'b0;
	logic ab_seen = 1'b0;
	logic grp_all, grp_ab, permit, ab_req, rise, learn;
	int miscompares = 0;
	int samples_checked = 0;
	int seed = 32'h08253263;
	logic [31:0] rd;
	logic [1:0] rr;
	logic [31:0] adj = '0;
	logic [7:0] reg_a [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
	logic [31:0] reg_v [7] = '{32'h10, 32'h0, 32'h0, 32'h7FFF8000, 32'h0, 32'h0, 32'h0};
	always #12.5 aclk = ~aclk;
	always @(posedge aclk)
		if (ab_req)
			ab_seen <= 1'b1;
	rlps_top #(
		.LEARN_TMO_CYC(rlps_tmo_t'(TMO)),
		.PFAIL_CYC(rlps_pf_t'(PF))
	) u_dut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_req(req), .s_axi_rsp(rsp),
		.measured_value(pv), .pv_under(pv_under), .pv_over(pv_over), .sensor_break(brk),
		.power_fail(pwr), .instrument_fail(ifail), .grp_permit_all(grp_all),
		.grp_abort(grp_ab), .local_permit(permit), .rise_abort_req(ab_req),
		.rise_active(rise), .learn_active(learn)
	);
	rlps_peer_model u_peers (
		.aclk(aclk), .aresetn(aresetn), .local_permit(permit), .rise_abort_req(ab_req),
		.peer_ok(peer_ok), .peer_abort(peer_abort), .slow(slow),
		.grp_permit_all(grp_all), .grp_abort(grp_ab)
	);
	task automatic final_report;
		$display("compares %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string m);
		samples_checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp, input string m);
		samples_checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("MISMATCH t=%0t %s got %b exp %b", $time, m, got, exp);
		end
	endtask
	// One bus transfer; entered just after a rising edge, left just after one
	task automatic ax(input logic wr, input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		int n;
		ta = 1'b0;
		tw = !wr;
		tb = 1'b0;
		n = 0;
		if (wr)
		begin
			req.awaddr <= a;
			req.wdata <= d;
			req.wstrb <= 4'hF;
			req.awvalid <= 1'b1;
			req.wvalid <= 1'b1;
			req.bready <= 1'b1;
		end
		else
		begin
			req.araddr <= a;
			req.arvalid <= 1'b1;
			req.rready <= 1'b1;
		end
		while (!tb && n < 100)
		begin
			// Ready and valid are settled by mid-cycle and hold through the edge
			@(negedge aclk);
			ta = ta | (wr ? rsp.awready : rsp.arready);
			tw = tw | rsp.wready;
			tb = wr ? rsp.bvalid : rsp.rvalid;
			rr = wr ? rsp.bresp : rsp.rresp;
			rd = rsp.rdata;
			@(posedge aclk);
			if (ta && (req.awvalid || req.arvalid))
			begin
				req.awvalid <= 1'b0;
				req.arvalid <= 1'b0;
			end
			if (tw && req.wvalid)
				req.wvalid <= 1'b0;
			n++;
		end
		req.bready <= 1'b0;
		req.rready <= 1'b0;
		// Let an edge pass so the next call never reassigns in this time step
		@(posedge aclk);
		chk_bit(tb, 1'b1, "bus answer");
	endtask
	function automatic logic exp_permit(logic [7:0] c, int g, int sv, int v, logic [2:0] fl);
		logic dir;
		dir = (c[7:5] == 3'h1) ? (sv < v) : (sv > v);
		return c[0] && !c[1] && !c[2] && !c[4] && c[7:5] <= 3'h4 && dir && g != 0
			&& fl == 3'h0 && v >= -100 && v <= 100;
	endfunction
	task automatic learn_case(input int k);
		pv <= '0;
		pv_over <= 1'b0;
		pwr <= 1'b0;
		ifail <= 1'b0;
		repeat (8) @(posedge aclk);
		ax(1'b1, 8'h00, 32'h11);
		ax(1'b1, 8'h14, 32'h8);
		ax(1'b1, 8'h14, 32'h1);
		chk_bit(learn, 1'b1, "learn start");
		case (k)
			1: ax(1'b1, 8'h00, 32'h01);
			2:
			begin
				adj = adj ^ ($random(seed) | 1);
				ax(1'b1, 8'h08, adj);
			end
			3: ax(1'b1, 8'h00, 32'h10);
			4: ax(1'b1, 8'h00, 32'h15);
			5: ax(1'b1, 8'h00, 32'h19);
			6: pv_over <= 1'b1;
			7: pv <= 16'sh0064;
			8:
			begin
				repeat (TMO - 10) @(posedge aclk);
				chk_bit(learn, 1'b1, "learn before timeout");
				repeat (15) @(posedge aclk);
			end
			9:
			begin
				pwr <= 1'b1;
				repeat (PF / 2) @(posedge aclk);
				pwr <= 1'b0;
				repeat (PF) @(posedge aclk);
				chk_bit(learn, 1'b1, "short supply dip");
				pwr <= 1'b1;
				repeat (PF + 8) @(posedge aclk);
			end
			10: ifail <= 1'b1;
			default: pv <= -16'sh0064;
		endcase
		repeat (k > 8 ? 8 : 2) @(posedge aclk);
		chk_bit(learn, 1'b0, "learn aborted");
		ax(1'b0, 8'h18, '0);
		chk_word(rd & 32'h1F0, 32'((k == 11 ? 7 : k) << 5) | 32'h10, "abort cause");
		ax(1'b0, 8'h00, '0);
		chk_bit(rd[4], k != 1, "learn setting kept");
	endtask
	initial
	begin
		#(25 * 20000);
		miscompares++;
		final_report;
	end
	initial
	begin
		logic [7:0] ctl;
		logic [2:0] fl;
		int g, sv, pvi;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk_bit(learn | rise | permit | ab_req, 1'b0, "outputs after reset");
		for (int i = 0; i < 7; i++)
		begin
			ax(1'b0, reg_a[i], '0);
			chk_word(rd, reg_v[i], "reset value");
		end
		ax(1'b0, 8'h1C, '0);
		chk_word(32'(rr), 32'h2, "unmapped read");
		ax(1'b1, 8'h1C, '1);
		chk_word(32'(rr), 32'h2, "unmapped write");
		ax(1'b1, 8'h0C, 32'h0064FF9C);
		for (int k = 1; k <= 11; k++)
			learn_case(k);
		pv_over <= 1'b0;
		pwr <= 1'b0;
		ifail <= 1'b0;
		pv <= '0;
		repeat (8) @(posedge aclk);
		ax(1'b1, 8'h00, 32'h11);
		ax(1'b1, 8'h14, 32'h1);
		chk_bit(learn, 1'b1, "learn start before done");
		ax(1'b1, 8'h14, 32'h2);
		chk_bit(learn, 1'b0, "learn done");
		ax(1'b0, 8'h00, '0);
		chk_bit(rd[4], 1'b0, "learn setting off after done");
		for (int i = 0; i < 30; i++)
		begin
			ctl = {3'(i % 6), i % 13 == 6, 1'b0, i % 11 == 5, i % 7 == 3, i % 9 != 4};
			g = (i + 1) % 5;
			sv = (i == 0) ? 120 : (i == 1) ? -150 : $random(seed) % 151;
			pvi = (i == 0) ? 100 : (i == 1) ? -100 : $random(seed) % 121;
			fl = (i % 4 == 2) ? 3'($random(seed)) : 3'h0;
			ax(1'b1, 8'h00, 32'(ctl));
			ax(1'b1, 8'h04, 32'(g));
			ax(1'b1, 8'h10, 32'(sv));
			pv <= 16'(pvi);
			{pv_under, pv_over, brk} <= fl;
			repeat (3) @(posedge aclk);
			chk_bit(permit, exp_permit(ctl, g, sv, pvi, fl), "permit");
		end
		{pv_under, pv_over, brk} <= 3'h0;
		pv <= '0;
		ax(1'b1, 8'h00, 32'h01);
		ax(1'b1, 8'h04, 32'h3);
		ax(1'b1, 8'h10, 32'h32);
		repeat (8) @(posedge aclk);
		ax(1'b1, 8'h14, 32'h4);
		chk_bit(rise, 1'b0, "rise without peers");
		peer_ok <= 1'b1;
		for (int j = 0; j < 3; j++)
		begin
			repeat (12) @(posedge aclk);
			ax(1'b1, 8'h14, 32'h4);
			chk_bit(rise, 1'b1, "rise started");
			slow <= j[0];
			case (j)
				0: peer_abort <= 1'b1;
				1: brk <= 1'b1;
				default: ax(1'b1, 8'h04, 32'h0);
			endcase
			repeat (12) @(posedge aclk);
			chk_bit(rise, 1'b0, "rise stopped");
			peer_abort <= 1'b0;
			brk <= 1'b0;
		end
		chk_bit(ab_seen, 1'b1, "abort told to peers");
		final_report;
	end
endmodule
`default_nettype wire

// >>> hw/rlps_map.svh
// Register offsets, reset values and timing figures of the rise supervisor.
// Assumes a 40 MHz aclk; included by the top-level design file by bare name.
`ifndef RLPS_MAP_SVH
`define RLPS_MAP_SVH

`define RLPS_A_CTRL 8'h00
`define RLPS_A_GROUP 8'h04
`define RLPS_A_PVADJ 8'h08
`define RLPS_A_LIM 8'h0C
`define RLPS_A_SV 8'h10
`define RLPS_A_CMD 8'h14
`define RLPS_A_STAT 8'h18

`define RLPS_CTRL_RST 8'h10
`define RLPS_LIM_RST 32'h7FFF8000
`define RLPS_GROUP_OFF 5'h00

`define RLPS_RESP_OKAY 2'h0
`define RLPS_RESP_SLVERR 2'h2

`define RLPS_CLK_HZ 64'h0000000002625A00
`define RLPS_SEC_PER_MIN 64'h3C
`define RLPS_MS_PER_SEC 64'h3E8
`define RLPS_LEARN_TMO_MIN 64'h64
`define RLPS_PFAIL_MS 64'h14

`endif

// >>> hw/rlps_pkg.sv
// Types shared by the rise supervisor files.
// Assumes nothing beyond a SystemVerilog compiler.
package rlps_pkg;

	typedef logic signed [15:0] rlps_pv_t;
	typedef logic [37:0] rlps_tmo_t;
	typedef logic [19:0] rlps_pf_t;

	typedef enum logic [2:0] {
		ct_rev, ct_dir, ct_hc_air, ct_hc_water, ct_hc_lin, ct_onoff
	} rlps_ctype_t;

	typedef struct packed {
		rlps_ctype_t ctype;
		logic learn_on;
		logic remote;
		logic manual;
		logic autotune;
		logic run;
	} rlps_ctrl_t;

	typedef struct packed {
		rlps_pv_t hi;
		rlps_pv_t lo;
	} rlps_lim_t;

	typedef struct packed {
		logic clr_abort;
		logic rise_go;
		logic learn_done;
		logic learn_go;
	} rlps_cmd_t;

	typedef enum logic [3:0] {
		cs_none, cs_lrn_off, cs_pvadj, cs_stop, cs_manual, cs_remote,
		cs_scale, cs_err, cs_tmo, cs_power, cs_fail
	} rlps_cause_t;

	typedef struct packed {
		rlps_cause_t cause;
		logic abort_seen;
		logic grp_all;
		logic rise_act;
		logic permit;
		logic learn_act;
	} rlps_stat_t;

	typedef struct packed {
		logic grp_abort;
		logic grp_all;
		logic fail;
		logic pwr;
	} rlps_async_t;

	typedef struct packed {
		logic awvalid;
		logic [7:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [7:0] araddr;
		logic rready;
	} rlps_axi_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} rlps_axi_rsp_t;

endpackage

// >>> hw/rlps_sync3.sv
// Three-stage input synchroniser for pins from outside the aclk domain.
// Assumes inputs may change at any time; output follows once stages 2 and 3 agree.
`timescale 1ns/1ps
`default_nettype none
module rlps_sync3 #(
	parameter int W = 1
)(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Raw and settled levels
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} rlps_sy_t;

	rlps_sy_t r;
	rlps_sy_t n;
	logic [W-1:0] agree;

	// Stage 1 feeds stage 2 only, so it never drives a decision
	assign agree = ~(r.s2 ^ r.s3);

	always_comb
	begin
		n = r;
		n.s1 = din;
		n.s2 = r.s1;
		n.s3 = r.s2;
		n.q = (r.s3 & agree) | (r.q & ~agree);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			r <= '0;
		else
			r <= n;
	end

	assign dout = r.q;
endmodule
`default_nettype wire

// >>> hw/rlps_top.sv
// Learning-abort and synchronised-rise permit supervisor with AXI4-Lite registers.
// Assumes measured value, scale and break flags come from logic on aclk;
// supply, fault and group lines are asynchronous pins.
// Behaviour
// - Any abort condition stops an active learning run at once.
// - An abort leaves the learning setting on.
// - Writing the learning setting off aborts learning.
// - Changing bias, input filter or ratio aborts learning.
// - Run to halt transition aborts learning.
// - Switching to manual aborts learning.
// - Switching to remote aborts learning.
// - Measured value under or over scale aborts learning.
// - Measured value at or beyond an error limit aborts learning.
// - Learning not finished after about 100 minutes is aborted.
// - Supply loss longer than 20 ms aborts learning.
// - Instrument fault aborts learning.
// - Rise starts only when every group member gives its permit.
// - Permit needs run, no autotune, auto, and a PID or heat/cool type.
// - Permit needs value in scale, no break, and within error limits.
// - Reverse and heat/cool need setpoint above value; direct needs below.
// - Heat/cool may only rise in the increasing direction.
// - Startup tuning neither blocks nor is blocked by the rise.
// - Group zero never takes part in a rise.
// - Any member's rise abort stops the whole group's rise.
//
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "rlps_map.svh"
module rlps_top #(
	parameter rlps_pkg::rlps_tmo_t LEARN_TMO_CYC = rlps_pkg::rlps_tmo_t'(
		`RLPS_LEARN_TMO_MIN * `RLPS_SEC_PER_MIN * `RLPS_CLK_HZ),
	parameter rlps_pkg::rlps_pf_t PFAIL_CYC = rlps_pkg::rlps_pf_t'(
		`RLPS_PFAIL_MS * `RLPS_CLK_HZ / `RLPS_MS_PER_SEC)
)(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus
	input wire rlps_pkg::rlps_axi_req_t s_axi_req,
	output rlps_pkg::rlps_axi_rsp_t s_axi_rsp,
	// Measurement, same clock
	input wire rlps_pkg::rlps_pv_t measured_value,
	input wire logic pv_under,
	input wire logic pv_over,
	input wire logic sensor_break,
	// Asynchronous pins
	input wire logic power_fail,
	input wire logic instrument_fail,
	input wire logic grp_permit_all,
	input wire logic grp_abort,
	// Group and controller outputs
	output logic local_permit,
	output logic rise_abort_req,
	output logic rise_active,
	output logic learn_active
);
	import rlps_pkg::*;

	typedef struct packed {
		logic aw_h;
		logic [7:0] awaddr;
		logic w_h;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		rlps_ctrl_t ctrl;
		logic [4:0] group;
		logic [31:0] pvadj;
		rlps_lim_t lim;
		rlps_pv_t sv;
		logic learn_act;
		rlps_tmo_t tmo;
		rlps_pf_t pfc;
		logic permit;
		logic rise_act;
		logic rabort;
		logic abort_seen;
		rlps_cause_t cause;
	} rlps_st_t;

	rlps_st_t r;
	rlps_st_t n;
	rlps_async_t as_raw;
	rlps_async_t as_s;
	rlps_stat_t stat;
	rlps_ctrl_t new_ctrl;
	rlps_cmd_t cmd;
	rlps_cause_t cause_nxt;
	logic [31:0] wmerge;
	logic aw_rdy;
	logic w_rdy;
	logic ar_rdy;
	logic wr_go;
	logic wr_ctrl;
	logic ev_lrn_off;
	logic ev_pvadj;
	logic ev_stop;
	logic ev_man;
	logic ev_rem;
	logic pv_scale;
	logic pv_err;
	logic pv_in_rng;
	logic tmo_hit;
	logic pwr_long;
	logic ct_pid;
	logic ct_hc;
	logic dir_ok;
	logic permit_nxt;
	logic rise_cond;
	logic rise_stop;
	logic rise_go;
	logic lrn_abort;

	function automatic logic [31:0] rd_word(input rlps_st_t s, input rlps_stat_t st,
		input logic [7:0] a);
		logic [31:0] v;
		v = 32'h0;
		case (a)
			`RLPS_A_CTRL: v = 32'(s.ctrl);
			`RLPS_A_GROUP: v = 32'(s.group);
			`RLPS_A_PVADJ: v = s.pvadj;
			`RLPS_A_LIM: v = s.lim;
			`RLPS_A_SV: v = 32'(unsigned'(s.sv));
			`RLPS_A_STAT: v = 32'(st);
			default: v = 32'h0;
		endcase
		return v;
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		return a inside {`RLPS_A_CTRL, `RLPS_A_GROUP, `RLPS_A_PVADJ, `RLPS_A_LIM,
			`RLPS_A_SV, `RLPS_A_CMD, `RLPS_A_STAT};
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] v;
		v = old;
		for (int i = 0; i < 4; i++)
		begin
			if (be[i])
				v[i*8 +: 8] = wd[i*8 +: 8];
		end
		return v;
	endfunction

	// Supply, fault and group lines are not on aclk
	assign as_raw.grp_abort = grp_abort;
	assign as_raw.grp_all = grp_permit_all;
	assign as_raw.fail = instrument_fail;
	assign as_raw.pwr = power_fail;

	rlps_sync3 #(
		.W($bits(rlps_async_t))
	) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.din(as_raw),
		.dout(as_s)
	);

	assign stat.cause = r.cause;
	assign stat.abort_seen = r.abort_seen;
	assign stat.grp_all = as_s.grp_all;
	assign stat.rise_act = r.rise_act;
	assign stat.permit = r.permit;
	assign stat.learn_act = r.learn_act;

	// Bus handshake; one write in flight, response must drain first
	assign aw_rdy = !r.aw_h && !r.bvalid;
	assign w_rdy = !r.w_h && !r.bvalid;
	assign ar_rdy = !r.rvalid;
	assign wr_go = r.aw_h && r.w_h && !r.bvalid;
	assign wmerge = merge(rd_word(r, stat, r.awaddr), r.wdata, r.wstrb);
	assign new_ctrl = rlps_ctrl_t'(wmerge[$bits(rlps_ctrl_t)-1:0]);
	assign wr_ctrl = wr_go && (r.awaddr == `RLPS_A_CTRL);
	assign cmd = (wr_go && (r.awaddr == `RLPS_A_CMD)) ?
		rlps_cmd_t'(wmerge[$bits(rlps_cmd_t)-1:0]) : rlps_cmd_t'('0);

	// Mode-change events seen on the write that makes them
	assign ev_lrn_off = wr_ctrl && r.ctrl.learn_on && !new_ctrl.learn_on;
	assign ev_pvadj = wr_go && (r.awaddr == `RLPS_A_PVADJ) && (wmerge != r.pvadj);
	assign ev_stop = wr_ctrl && r.ctrl.run && !new_ctrl.run;
	assign ev_man = wr_ctrl && !r.ctrl.manual && new_ctrl.manual;
	assign ev_rem = wr_ctrl && !r.ctrl.remote && new_ctrl.remote;

	assign pv_scale = pv_under || pv_over;
	assign pv_err = (measured_value >= r.lim.hi) || (measured_value <= r.lim.lo);
	assign pv_in_rng = (measured_value <= r.lim.hi) && (measured_value >= r.lim.lo);
	assign tmo_hit = r.tmo == LEARN_TMO_CYC;
	// Strictly longer than the limit, so a drop of exactly 20 ms is tolerated
	assign pwr_long = r.pfc > PFAIL_CYC;

	assign lrn_abort = r.learn_act && (ev_lrn_off || ev_pvadj || ev_stop || ev_man
		|| ev_rem || pv_scale || pv_err || tmo_hit || pwr_long || as_s.fail);

	assign cause_nxt = ev_lrn_off ? cs_lrn_off :
		ev_pvadj ? cs_pvadj :
		ev_stop ? cs_stop :
		ev_man ? cs_manual :
		ev_rem ? cs_remote :
		pv_scale ? cs_scale :
		pv_err ? cs_err :
		tmo_hit ? cs_tmo :
		pwr_long ? cs_power :
		cs_fail;

	assign ct_pid = r.ctrl.ctype inside {ct_rev, ct_dir};
	assign ct_hc = r.ctrl.ctype inside {ct_hc_air, ct_hc_water, ct_hc_lin};
	// Heat/cool falls in the setpoint-above branch, so it only ever rises
	assign dir_ok = (r.ctrl.ctype == ct_dir) ? (r.sv < measured_value) :
		(r.sv > measured_value);

	// Startup tuning is deliberately not a term here: both may run together
	assign permit_nxt = r.ctrl.run && !r.ctrl.autotune && !r.ctrl.manual
		&& (ct_pid || ct_hc)
		&& !pv_scale && !sensor_break && pv_in_rng
		&& dir_ok
		&& (r.group != `RLPS_GROUP_OFF) && !r.ctrl.learn_on;

	assign rise_cond = !r.ctrl.run || r.ctrl.autotune || r.ctrl.manual
		|| (r.ctrl.ctype == ct_onoff) || pv_scale || sensor_break || pv_err
		|| pwr_long || as_s.fail;
	assign rise_stop = rise_cond || as_s.grp_abort
		|| (r.group == `RLPS_GROUP_OFF);
	assign rise_go = cmd.rise_go && r.permit && as_s.grp_all && !rise_stop;

	always_comb
	begin
		n = r;
		if (s_axi_req.awvalid && aw_rdy)
		begin
			n.aw_h = 1'b1;
			n.awaddr = s_axi_req.awaddr;
		end
		if (s_axi_req.wvalid && w_rdy)
		begin
			n.w_h = 1'b1;
			n.wdata = s_axi_req.wdata;
			n.wstrb = s_axi_req.wstrb;
		end
		if (r.bvalid && s_axi_req.bready)
			n.bvalid = 1'b0;
		if (wr_go)
		begin
			n.aw_h = 1'b0;
			n.w_h = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = mapped(r.awaddr) ? `RLPS_RESP_OKAY : `RLPS_RESP_SLVERR;
			case (r.awaddr)
				`RLPS_A_CTRL: n.ctrl = new_ctrl;
				`RLPS_A_GROUP: n.group = wmerge[$bits(r.group)-1:0];
				`RLPS_A_PVADJ: n.pvadj = wmerge;
				`RLPS_A_LIM: n.lim = wmerge;
				`RLPS_A_SV: n.sv = wmerge[$bits(rlps_pv_t)-1:0];
				default: n.bresp = n.bresp;
			endcase
		end
		if (r.rvalid && s_axi_req.rready)
			n.rvalid = 1'b0;
		if (s_axi_req.arvalid && ar_rdy)
		begin
			n.rvalid = 1'b1;
			n.rdata = rd_word(r, stat, s_axi_req.araddr);
			n.rresp = mapped(s_axi_req.araddr) ? `RLPS_RESP_OKAY : `RLPS_RESP_SLVERR;
		end

		if (!as_s.pwr)
			n.pfc = '0;
		else if (!pwr_long)
			n.pfc = r.pfc + 1'b1;

		if (r.learn_act)
			n.tmo = r.tmo + 1'b1;
		// The learning setting is left alone on abort
		if (lrn_abort)
		begin
			n.learn_act = 1'b0;
			n.cause = cause_nxt;
		end
		else if (cmd.learn_done && r.learn_act)
		begin
			n.learn_act = 1'b0;
			n.ctrl.learn_on = 1'b0;
		end
		// A start during a fault would only be aborted on the next edge
		else if (cmd.learn_go && r.ctrl.learn_on && !r.learn_act && !as_s.fail)
		begin
			n.learn_act = 1'b1;
			n.tmo = '0;
		end

		n.permit = permit_nxt;
		n.rabort = r.rise_act && rise_cond;
		if (rise_stop)
			n.rise_act = 1'b0;
		else if (rise_go)
			n.rise_act = 1'b1;

		// A new abort in the clearing cycle keeps the flag set
		n.abort_seen = lrn_abort || (r.rise_act && rise_stop)
			|| (r.abort_seen && !cmd.clr_abort);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			r <= '0;
			r.ctrl <= `RLPS_CTRL_RST;
			r.lim <= `RLPS_LIM_RST;
		end
		else
			r <= n;
	end

	assign s_axi_rsp.awready = aw_rdy;
	assign s_axi_rsp.wready = w_rdy;
	assign s_axi_rsp.bvalid = r.bvalid;
	assign s_axi_rsp.bresp = r.bresp;
	assign s_axi_rsp.arready = ar_rdy;
	assign s_axi_rsp.rvalid = r.rvalid;
	assign s_axi_rsp.rdata = r.rdata;
	assign s_axi_rsp.rresp = r.rresp;
	assign local_permit = r.permit;
	assign rise_abort_req = r.rabort;
	assign rise_active = r.rise_act;
	assign learn_active = r.learn_act;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_rise_start;
		!r.rise_act ##1 r.rise_act;
	endsequence

	property p_abort_any;
		lrn_abort |=> !r.learn_act && (r.cause == $past(cause_nxt));
	endproperty
	a_abort_any: assert property (p_abort_any)
		else $error("learning not halted on abort");
	property p_keep_on;
		lrn_abort && !ev_lrn_off && !wr_ctrl |=> r.ctrl.learn_on == $past(r.ctrl.learn_on);
	endproperty
	a_keep_on: assert property (p_keep_on)
		else $error("learning setting changed by abort");
	property p_lrn_off;
		r.learn_act && ev_lrn_off |=> !r.learn_act && r.cause == cs_lrn_off;
	endproperty
	a_lrn_off: assert property (p_lrn_off)
		else $error("learning kept after setting off");
	property p_pvadj;
		r.learn_act && ev_pvadj |=> !r.learn_act;
	endproperty
	a_pvadj: assert property (p_pvadj)
		else $error("learning kept after input adjust change");
	property p_stop;
		r.learn_act && wr_ctrl && r.ctrl.run && !new_ctrl.run |=> !r.learn_act && !r.ctrl.run;
	endproperty
	a_stop: assert property (p_stop)
		else $error("learning kept after stop");
	property p_manual;
		r.learn_act && ev_man |=> !r.learn_act && r.ctrl.manual;
	endproperty
	a_manual: assert property (p_manual)
		else $error("learning kept after manual");
	property p_remote;
		r.learn_act && ev_rem |=> !r.learn_act && r.ctrl.remote;
	endproperty
	a_remote: assert property (p_remote)
		else $error("learning kept after remote");
	property p_scale;
		r.learn_act && (pv_under || pv_over) |=> !r.learn_act;
	endproperty
	a_scale: assert property (p_scale)
		else $error("learning kept out of scale");
	property p_errlim;
		r.learn_act && (measured_value >= r.lim.hi) |=> !r.learn_act;
	endproperty
	a_errlim: assert property (p_errlim)
		else $error("learning kept at error limit");
	property p_tmo;
		r.learn_act |-> r.tmo <= LEARN_TMO_CYC;
	endproperty
	a_tmo: assert property (p_tmo)
		else $error("learning ran past its time limit");
	property p_pwr;
		$rose(pwr_long) |-> $past(r.pfc) == PFAIL_CYC && $past(as_s.pwr);
	endproperty
	a_pwr: assert property (p_pwr)
		else $error("supply loss length misjudged");
	property p_fail;
		as_s.fail |=> !r.learn_act && !r.rise_act;
	endproperty
	a_fail: assert property (p_fail)
		else $error("activity kept during instrument fault");
	property p_grp;
		s_rise_start |-> $past(as_s.grp_all) && $past(r.permit);
	endproperty
	a_grp: assert property (p_grp)
		else $error("rise started without group permit");
	property p_mode;
		r.permit |-> $past(r.ctrl.run && !r.ctrl.autotune && !r.ctrl.manual
			&& (r.ctrl.ctype != ct_onoff));
	endproperty
	a_mode: assert property (p_mode)
		else $error("permit with wrong mode");
	property p_input;
		r.permit |-> $past(!pv_scale && !sensor_break && pv_in_rng);
	endproperty
	a_input: assert property (p_input)
		else $error("permit with invalid input");
	property p_direct;
		r.permit && $past(r.ctrl.ctype == ct_dir) |-> $past(r.sv < measured_value);
	endproperty
	a_direct: assert property (p_direct)
		else $error("direct action permit with setpoint not below value");
	property p_hc_up;
		r.permit && $past(ct_hc) |-> $past(r.sv > measured_value);
	endproperty
	a_hc_up: assert property (p_hc_up)
		else $error("heat/cool permit not rising");
	property p_learn_off;
		r.permit |-> $past(!r.ctrl.learn_on && r.group != `RLPS_GROUP_OFF);
	endproperty
	a_learn_off: assert property (p_learn_off)
		else $error("permit with learning on or group zero");
	property p_group0;
		r.group == `RLPS_GROUP_OFF |=> !r.rise_act;
	endproperty
	a_group0: assert property (p_group0)
		else $error("group zero in a rise");
	property p_grp_abort;
		r.rise_act && (as_s.grp_abort || rise_cond) |=> !r.rise_act;
	endproperty
	a_grp_abort: assert property (p_grp_abort)
		else $error("rise kept after group abort");
endmodule
`default_nettype wire
